// >>> sim/sms_cpu_model.sv
// CPU core and interrupt controller context facing the stop controller
`timescale 1ns/1ps
`default_nettype none

module sms_cpu_model
  import sms_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       cpu_clk_en,
  input  wire logic       wake_ack,
  output logic            in_handler,
  output logic            interrupts_enabled_state,
  output logic      [2:0] service_prio,
  output logic      [2:0] request_prio,
  output int              ack_cnt,
  output int              instr_cnt
);
  // ==================================================
  // Context levels, changed only after a clock edge
  initial begin
    in_handler = 1'b0;
    interrupts_enabled_state = 1'b0;
    service_prio = 3'h0;
    request_prio = 3'h0;
  end

  task automatic set_ctx(input logic h, input logic ie,
                         input logic [2:0] s, input logic [2:0] r);
    @(posedge clk);
    in_handler <= h;
    interrupts_enabled_state <= ie;
    service_prio <= s;
    request_prio <= r;
  endtask

  // ==================================================
  // Instruction slots only tick while the core clock runs
  always @(posedge clk) begin
    if (!resetn) begin
      ack_cnt <= 0;
      instr_cnt <= 0;
    end else begin
      if (wake_ack) begin
        ack_cnt <= ack_cnt + 1;
      end
      if (cpu_clk_en) begin
        instr_cnt <= instr_cnt + 1;
      end
    end
  end
endmodule

`default_nettype wire

// >>> sim/stop_mode_standby_control_tb.sv
// Self-checking bench of the stop mode standby controller
`timescale 1ns/1ps
`default_nettype none

module stop_mode_standby_control_tb
  import sms_pkg::*;
;
  localparam int RST_N = 16;
  logic        clk, resetn, wr, rd, nmi_pin, periph_irq, wd2_int, wd2_rst;
  logic        reset_pin_n, in_handler, ie_state, irq, cpu_clk_en, per_en;
  logic        main_osc_en, sub_osc_en, ram_hold, port_hold, sys_reset_req;
  logic        wake_ack, retained, main_domain_run;
  logic [7:0]  addr, ext_pins;
  logic [15:0] wdata, rdata, rv;
  logic [2:0]  sprio, rprio;
  logic [5:0]  runs;
  sms_act_t    wake_action;
  int          err_total, compares, cyc, ack_cnt, instr_cnt;

  // ==================================================
  // Clock, timeout and instances
  initial clk = 1'b0;
  always #50 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total = err_total + 1;
      results();
    end
  end

  sms_stop_ctrl #(.RESET_STAB_CYCLES(RST_N)) u_sms_stop_ctrl (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .nmi_pin(nmi_pin),
    .external_interrupt_pins(ext_pins), .periph_irq(periph_irq),
    .second_watchdog_interrupt(wd2_int), .second_watchdog_reset(wd2_rst),
    .reset_pin_n(reset_pin_n), .in_handler(in_handler),
    .interrupts_enabled_state(ie_state), .service_prio(sprio),
    .request_prio(rprio), .cpu_clk_en(cpu_clk_en),
    .periph_main_clk_en(per_en), .main_osc_en(main_osc_en),
    .sub_osc_en(sub_osc_en), .ram_hold(ram_hold), .port_hold(port_hold),
    .sys_reset_req(sys_reset_req), .wake_action(wake_action),
    .wake_ack(wake_ack), .request_retained(retained),
    .sixteen_bit_timer_run(runs[5]), .eight_bit_timer_a_run(runs[4]),
    .eight_bit_timer_b_run(runs[3]), .second_timer_h_run(runs[2]),
    .watch_timer_run(runs[1]), .second_watchdog_run(runs[0]),
    .main_domain_run(main_domain_run));

  sms_cpu_model u_sms_cpu_model (
    .clk(clk), .resetn(resetn), .cpu_clk_en(cpu_clk_en),
    .wake_ack(wake_ack), .in_handler(in_handler),
    .interrupts_enabled_state(ie_state), .service_prio(sprio),
    .request_prio(rprio), .ack_cnt(ack_cnt), .instr_cnt(instr_cnt));

  // ==================================================
  // Shared tasks and expectations
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Order: t16, t8a, t8b, timer H two, watch timer, watchdog two
  function automatic logic [5:0] run_exp(input logic [9:0] c);
    logic s;
    s = c[0];
    // Match source only ticks while the 16-bit timer runs in stop
    return {s & c[1] & c[2], c[3] | (s & c[1] & c[2] & c[5] & c[7]),
            c[4] | (s & c[1] & c[2] & c[6] & c[7]), s & c[8], s & c[2],
            s & c[9]};
  endfunction

  task automatic enter_stop(input logic [3:0] pc, input logic [9:0] c);
    int n0;
    wr_reg(8'h00, 16'h0001);
    wr_reg(8'h04, {12'h000, pc});
    #1;
    n0 = instr_cnt;
    chk(cpu_clk_en, 1'b0);
    chk(per_en, 1'b0);
    chk(main_osc_en, 1'b0);
    chk(sub_osc_en, c[0]);
    chk({ram_hold, port_hold}, 2'b11);
    chk(main_domain_run, 1'b0);
    chk(runs[5], 1'(run_exp(c) >> 5));
    chk(runs[4:3], 2'(run_exp(c) >> 3));
    chk(runs[2:0], 3'(run_exp(c)));
    repeat (5) @(posedge clk);
    chk(16'(instr_cnt - n0), 16'h0000);
  endtask

  task automatic wait_wake(output int n);
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 1200) begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
  endtask

  // One stop and wake; src 0 pin NMI, 1 pin, 2 peripheral, 3 watchdog two
  task automatic wake_case(input int src, input logic h, input logic ie);
    logic [9:0] c;
    logic [2:0] s, r;
    logic       nmi, take;
    int         n, a0;
    c = 10'($urandom);
    s = 3'($urandom);
    r = 3'($urandom);
    if (src == 3) c = c | 10'h201;
    nmi = (src == 0 || src == 3);
    take = nmi || (!(h && r <= s) && ie);
    wr_reg(8'h0C, {6'h00, c});
    wr_reg(8'h08, 16'h0000);
    wr_reg(8'h10, 16'h0000);
    wr_reg(8'h18, 16'h0007);
    u_sms_cpu_model.set_ctx(h, ie, s, r);
    enter_stop(4'h1, c);
    chk(irq, 1'b1);
    a0 = ack_cnt;
    @(posedge clk);
    case (src)
      0: nmi_pin <= 1'b1;
      1: ext_pins <= 8'h01 << ($urandom % 8);
      2: periph_irq <= 1'b1;
      default: wd2_int <= 1'b1;
    endcase
    wait_wake(n);
    chk(wake_action, take ? SMS_ACT_VECTOR : SMS_ACT_NEXT);
    chk(16'(n >= 1024 && n <= 1032), 16'h0001);
    repeat (3) @(posedge clk);
    #1;
    chk(16'(ack_cnt - a0), 16'(take));
    if (h && !nmi && r <= s) chk(retained, 1'b1);
    nmi_pin <= 1'b0;
    ext_pins <= 8'h00;
    periph_irq <= 1'b0;
    wd2_int <= 1'b0;
    u_sms_cpu_model.set_ctx(1'b0, 1'b1, 3'h0, 3'h0);
    wr_reg(8'h14, 16'h0007);
    repeat (6) @(posedge clk);
    #1;
    chk(irq, 1'b0);
    chk(retained, 1'b0);
    $display("wake case src=%0d handler=%0d done", src, h);
  endtask

  // ==================================================
  // Main sequence
  initial begin
    int n;
    logic [9:0] c;
    {resetn, wr, rd, nmi_pin, periph_irq, wd2_int, wd2_rst} = 7'h00;
    reset_pin_n = 1'b1;
    addr = 8'h00;
    wdata = 16'h0000;
    ext_pins = 8'h00;
    err_total = 0;
    compares = 0;
    cyc = 0;
    void'($urandom(32'h8bbc7c4d));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd_reg(8'h08, rv);
    chk(rv, 16'h0007);
    rd_reg(8'h20, rv);
    chk(rv, 16'h0000);
    wr_reg(8'h04, 16'h0001);
    #1;
    chk(cpu_clk_en, 1'b1);
    chk(main_domain_run, 1'b1);
    $display("reset and refused entry done");
    for (int i = 0; i < 12; i++) begin
      wake_case(i % 4, 1'(i / 4 == 1), 1'(i / 4 != 2));
    end
    c = 10'h000;
    wr_reg(8'h0C, 16'h0000);
    wr_reg(8'h10, 16'h00FE);
    wr_reg(8'h18, 16'h0000);
    enter_stop(4'h5, c);
    chk(irq, 1'b0);
    nmi_pin <= 1'b1;
    ext_pins <= 8'h02;
    repeat (20) @(posedge clk);
    #1;
    chk(cpu_clk_en, 1'b0);
    ext_pins <= 8'h01;
    wait_wake(n);
    chk(16'(n >= 1024 && n <= 1032), 16'h0001);
    nmi_pin <= 1'b0;
    ext_pins <= 8'h00;
    $display("masked sources done");
    // Reset wake from the pin, then from watchdog two on the subclock
    for (int k = 0; k < 2; k++) begin
      c = (k == 1) ? 10'h201 : 10'h000;
      wr_reg(8'h0C, {6'h00, c});
      enter_stop(4'h1, c);
      if (k == 1) wd2_rst <= 1'b1;
      else reset_pin_n <= 1'b0;
      n = 0;
      while (sys_reset_req !== 1'b1 && n < 20) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      reset_pin_n <= 1'b1;
      wd2_rst <= 1'b0;
      n = 0;
      while (sys_reset_req === 1'b1 && n < 100) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      chk(16'(n >= RST_N && n <= RST_N + 1), 16'h0001);
      repeat (4) @(posedge clk);
      rd_reg(8'h08, rv);
      chk(rv, 16'h0007);
      rd_reg(8'h00, rv);
      chk(rv, 16'h0000);
      rd_reg(8'h0C, rv);
      chk(rv, 16'h0000);
      #1;
      chk({cpu_clk_en, main_osc_en, port_hold, sub_osc_en},
          4'b1100);
      $display("reset wake %0d done", k);
    end
    results();
  end
endmodule

`default_nettype wire

// >>> verilog/sms_defs.svh
// Offsets, field positions, reset values and counts of the stop controller
`ifndef SMS_DEFS_SVH
`define SMS_DEFS_SVH
// ==================================================
// Register offsets
`define SMS_PMR_OFF   8'h00
`define SMS_PCTL_OFF  8'h04
`define SMS_STAB_OFF  8'h08
`define SMS_CFG_OFF   8'h0C
`define SMS_EMSK_OFF  8'h10
`define SMS_ISTA_OFF  8'h14
`define SMS_IMSK_OFF  8'h18
`define SMS_STAT_OFF  8'h1C
// ==================================================
// Control register fields
`define SMS_PCTL_STOP 0
`define SMS_PCTL_MMSK 1
`define SMS_PCTL_PNMK 2
`define SMS_PCTL_WNMK 3
// Clock configuration fields
`define SMS_CFG_SUB   0
`define SMS_CFG_T16WT 1
`define SMS_CFG_WTSUB 2
`define SMS_CFG_T8AX  3
`define SMS_CFG_T8BX  4
`define SMS_CFG_T8AM  5
`define SMS_CFG_T8BM  6
`define SMS_CFG_T16EN 7
`define SMS_CFG_TH2S  8
`define SMS_CFG_WD2S  9
// Interrupt status fields
`define SMS_EV_STOP   0
`define SMS_EV_WAKE   1
`define SMS_EV_RUN    2
// ==================================================
// Reset values and timing
`define SMS_STAB_RST  3'h7
`define SMS_STAB_UNIT 16'h0400
`define SMS_RST_STAB  32768
`endif

// >>> verilog/sms_pkg.sv
// Types of the stop controller
package sms_pkg;
  typedef enum logic [1:0] {
    SMS_NORMAL,
    SMS_STOP,
    SMS_STAB
  } sms_state_t;
  typedef enum logic [1:0] {
    SMS_ACT_NONE,
    SMS_ACT_VECTOR,
    SMS_ACT_NEXT
  } sms_act_t;
  typedef struct packed {
    sms_state_t st;
    logic       pmode;
    logic [3:1] pctl;
    logic [2:0] stab_sel;
    logic [9:0] cfg;
    logic [7:0] emsk;
    logic [2:0] ista;
    logic [2:0] imsk;
    logic [2:0] s_nmi;
    logic [2:0] s_wd2i;
    logic [2:0] s_wd2r;
    logic [2:0] s_rstp;
    logic [2:0] s_per;
    logic [7:0] e1;
    logic [7:0] e2;
    logic [7:0] e3;
    logic       f_nmi;
    logic       f_wd2i;
    logic       f_wd2r;
    logic       f_rstp;
    logic       f_per;
    logic [7:0] f_ext;
    logic [15:0] cnt;
    logic       rst_wake;
    logic       nmi_wake;
    sms_act_t   act;
    logic       ack;
    logic       ack_pend;
    logic       retain;
    logic [15:0] rdata;
    logic       irq;
    logic       cpu_clk_en;
    logic       per_clk_en;
    logic       main_osc_en;
    logic       sub_osc_en;
    logic       ram_hold;
    logic       port_hold;
    logic       sys_rst;
    logic [5:0] run_sub;
    logic       run_main;
  } sms_st_t;
endpackage

// >>> verilog/sms_stop_ctrl.sv
// Stop mode standby controller: entry, clock gating, wake-up and wait
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "sms_defs.svh"

module sms_stop_ctrl
  import sms_pkg::*;
#(
  parameter int RESET_STAB_CYCLES = `SMS_RST_STAB
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  output logic             irq,
  input  wire logic        nmi_pin,
  input  wire logic [7:0]  external_interrupt_pins,
  input  wire logic        periph_irq,
  input  wire logic        second_watchdog_interrupt,
  input  wire logic        second_watchdog_reset,
  input  wire logic        reset_pin_n,
  input  wire logic        in_handler,
  input  wire logic        interrupts_enabled_state,
  input  wire logic [2:0]  service_prio,
  input  wire logic [2:0]  request_prio,
  output logic             cpu_clk_en,
  output logic             periph_main_clk_en,
  output logic             main_osc_en,
  output logic             sub_osc_en,
  output logic             ram_hold,
  output logic             port_hold,
  output logic             sys_reset_req,
  output sms_act_t         wake_action,
  output logic             wake_ack,
  output logic             request_retained,
  output logic             sixteen_bit_timer_run,
  output logic             eight_bit_timer_a_run,
  output logic             eight_bit_timer_b_run,
  output logic             second_timer_h_run,
  output logic             watch_timer_run,
  output logic             second_watchdog_run,
  output logic             main_domain_run
);

  // ==================================================
  // Helpers
  function automatic logic [15:0] stab_len(
    input logic [2:0] sel
  );
    stab_len = `SMS_STAB_UNIT * ({13'h0000, sel} + 16'h0001);
  endfunction

  function automatic logic bit_of(
    input logic [9:0] v,
    input int         i
  );
    bit_of = v[i];
  endfunction

  localparam logic [15:0] RST_CNT = 16'(RESET_STAB_CYCLES);

  sms_st_t q, d;

  logic       wk_nmi;
  logic       wk_wd2;
  logic       wk_mask;
  logic       wk_rst;
  logic       sub;
  logic       t16;
  logic [5:0] run_stop;
  logic [2:0] ev_set;

  // ==================================================
  // Next state
  always_comb begin
    d = q;
    ev_set = 3'b000;
    // Three-stage sync; a change counts when stages two and three agree
    d.s_nmi  = {q.s_nmi[1:0], nmi_pin};
    d.s_wd2i = {q.s_wd2i[1:0], second_watchdog_interrupt};
    d.s_wd2r = {q.s_wd2r[1:0], second_watchdog_reset};
    d.s_rstp = {q.s_rstp[1:0], ~reset_pin_n};
    d.s_per  = {q.s_per[1:0], periph_irq};
    d.e1     = external_interrupt_pins;
    d.e2     = q.e1;
    d.e3     = q.e2;
    if (q.s_nmi[1] == q.s_nmi[2]) begin
      d.f_nmi = q.s_nmi[2];
    end
    if (q.s_wd2i[1] == q.s_wd2i[2]) begin
      d.f_wd2i = q.s_wd2i[2];
    end
    if (q.s_wd2r[1] == q.s_wd2r[2]) begin
      d.f_wd2r = q.s_wd2r[2];
    end
    if (q.s_rstp[1] == q.s_rstp[2]) begin
      d.f_rstp = q.s_rstp[2];
    end
    if (q.s_per[1] == q.s_per[2]) begin
      d.f_per = q.s_per[2];
    end
    for (int i = 0; i < 8; i++) begin
      if (q.e2[i] == q.e3[i]) begin
        d.f_ext[i] = q.e3[i];
      end
    end

    sub = q.cfg[`SMS_CFG_SUB];
    // Masked sources never count as wake-ups
    wk_nmi = q.f_nmi & ~q.pctl[`SMS_PCTL_PNMK];
    wk_wd2 = q.f_wd2i & ~q.pctl[`SMS_PCTL_WNMK]
           & sub & bit_of(q.cfg, `SMS_CFG_WD2S);
    wk_mask = ~q.pctl[`SMS_PCTL_MMSK]
            & (q.f_per | (|(q.f_ext & ~q.emsk)));
    wk_rst = q.f_rstp
           | (q.f_wd2r & sub & bit_of(q.cfg, `SMS_CFG_WD2S));

    // Stop-mode run enables of the subclock and external clock users
    t16 = sub & bit_of(q.cfg, `SMS_CFG_T16WT)
        & bit_of(q.cfg, `SMS_CFG_WTSUB);
    run_stop[0] = t16;
    run_stop[1] = bit_of(q.cfg, `SMS_CFG_T8AX)
                | (sub & t16 & bit_of(q.cfg, `SMS_CFG_T8AM)
                   & bit_of(q.cfg, `SMS_CFG_T16EN));
    run_stop[2] = bit_of(q.cfg, `SMS_CFG_T8BX)
                | (sub & t16 & bit_of(q.cfg, `SMS_CFG_T8BM)
                   & bit_of(q.cfg, `SMS_CFG_T16EN));
    run_stop[3] = sub & bit_of(q.cfg, `SMS_CFG_TH2S);
    run_stop[4] = sub & bit_of(q.cfg, `SMS_CFG_WTSUB);
    run_stop[5] = sub & bit_of(q.cfg, `SMS_CFG_WD2S);

    d.ack     = 1'b0;
    d.sys_rst = 1'b0;

    unique case (q.st)
      SMS_NORMAL: begin
        d.act = SMS_ACT_NONE;
        // Software owes the no-op gap; the gating is immediate
        if (wr && addr == `SMS_PCTL_OFF && wdata[`SMS_PCTL_STOP]
            && q.pmode) begin
          d.st = SMS_STOP;
          ev_set[`SMS_EV_STOP] = 1'b1;
        end
      end
      SMS_STOP: begin
        if (wk_rst) begin
          d.st       = SMS_STAB;
          d.rst_wake = 1'b1;
          d.sys_rst  = 1'b1;
          d.cnt      = RST_CNT;
        end else if (wk_nmi | wk_wd2 | wk_mask) begin
          d.st       = SMS_STAB;
          d.rst_wake = 1'b0;
          d.nmi_wake = wk_nmi | wk_wd2;
          d.cnt      = stab_len(q.stab_sel);
          ev_set[`SMS_EV_WAKE] = 1'b1;
        end
      end
      SMS_STAB: begin
        d.cnt = q.cnt - 16'h0001;
        if (q.rst_wake) begin
          d.sys_rst = 1'b1;
        end
        if (q.cnt == 16'h0001) begin
          d.st = SMS_NORMAL;
          ev_set[`SMS_EV_RUN] = 1'b1;
          if (q.nmi_wake) begin
            d.act = SMS_ACT_VECTOR;
            d.ack = 1'b1;
          end else if (q.rst_wake) begin
            d.act = SMS_ACT_NONE;
          end else if (in_handler
                       && request_prio <= service_prio) begin
            d.act    = SMS_ACT_NEXT;
            d.retain = 1'b1;
          end else if (interrupts_enabled_state) begin
            d.act = SMS_ACT_VECTOR;
            d.ack = 1'b1;
          end else begin
            d.act    = SMS_ACT_NEXT;
            d.retain = 1'b1;
          end
        end
      end
    endcase

    if (ack_clear()) begin
      d.retain = 1'b0;
    end

    // Outputs follow the state being entered, except sub_osc_en, which follows the SUB configuration bit
    d.cpu_clk_en  = (d.st == SMS_NORMAL);
    d.per_clk_en  = (d.st == SMS_NORMAL);
    d.main_osc_en = (d.st != SMS_STOP);
    d.sub_osc_en  = q.cfg[`SMS_CFG_SUB];
    d.ram_hold    = (d.st != SMS_NORMAL);
    d.port_hold   = (d.st != SMS_NORMAL);
    d.run_main    = (d.st == SMS_NORMAL);
    d.run_sub     = (d.st == SMS_NORMAL) ? 6'h3F : run_stop;

    // Register writes; gating bits lock while the CPU is stopped
    if (wr && q.st == SMS_NORMAL) begin
      unique case (addr)
        `SMS_PMR_OFF:  d.pmode    = wdata[0];
        `SMS_PCTL_OFF: d.pctl     = wdata[3:1];
        `SMS_STAB_OFF: d.stab_sel = wdata[2:0];
        `SMS_CFG_OFF:  d.cfg      = wdata[9:0];
        `SMS_EMSK_OFF: d.emsk     = wdata[7:0];
        `SMS_IMSK_OFF: d.imsk     = wdata[2:0];
        default: ;
      endcase
    end
    // Hardware set wins over write-one-to-clear
    if (wr && addr == `SMS_ISTA_OFF) begin
      d.ista = q.ista & ~wdata[2:0];
    end
    d.ista = d.ista | ev_set;
    d.irq = |(d.ista & d.imsk);

    d.rdata = 16'h0000;
    if (rd) begin
      unique case (addr)
        `SMS_PMR_OFF:  d.rdata = {15'h0000, q.pmode};
        `SMS_PCTL_OFF: d.rdata = {12'h000, q.pctl, 1'b0};
        `SMS_STAB_OFF: d.rdata = {13'h0000, q.stab_sel};
        `SMS_CFG_OFF:  d.rdata = {6'h00, q.cfg};
        `SMS_EMSK_OFF: d.rdata = {8'h00, q.emsk};
        `SMS_ISTA_OFF: d.rdata = {13'h0000, q.ista};
        `SMS_IMSK_OFF: d.rdata = {13'h0000, q.imsk};
        `SMS_STAT_OFF: d.rdata = {11'h000, q.retain, q.rst_wake,
                                  q.nmi_wake, 2'(q.st)};
        default:       d.rdata = 16'h0000;
      endcase
    end

    // A reset wake ends exactly as a power-on reset does
    if (q.st == SMS_STAB && q.rst_wake && q.cnt == 16'h0001) begin
      d = reset_val();
    end
  end

  // Retained request is dropped once the CPU is out of the handler with interrupts enabled
  function automatic logic ack_clear();
    ack_clear = (q.st == SMS_NORMAL) && !in_handler && q.retain
              && interrupts_enabled_state;
  endfunction

  function automatic sms_st_t reset_val();
    sms_st_t r;
    r             = '0;
    r.st          = SMS_NORMAL;
    r.act         = SMS_ACT_NONE;
    r.stab_sel    = `SMS_STAB_RST;
    r.cpu_clk_en  = 1'b1;
    r.per_clk_en  = 1'b1;
    r.main_osc_en = 1'b1;
    r.run_main    = 1'b1;
    r.run_sub     = 6'h3F;
    r.cnt         = 16'h0001;
    reset_val     = r;
  endfunction

  // ==================================================
  // State register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= reset_val();
    end else begin
      q <= d;
    end
  end

  assign rdata                 = q.rdata;
  assign irq                   = q.irq;
  assign cpu_clk_en            = q.cpu_clk_en;
  assign periph_main_clk_en    = q.per_clk_en;
  assign main_osc_en           = q.main_osc_en;
  assign sub_osc_en            = q.sub_osc_en;
  assign ram_hold              = q.ram_hold;
  assign port_hold             = q.port_hold;
  assign sys_reset_req         = q.sys_rst;
  assign wake_action           = q.act;
  assign wake_ack              = q.ack;
  assign request_retained      = q.retain;
  assign sixteen_bit_timer_run = q.run_sub[0];
  assign eight_bit_timer_a_run = q.run_sub[1];
  assign eight_bit_timer_b_run = q.run_sub[2];
  assign second_timer_h_run    = q.run_sub[3];
  assign watch_timer_run       = q.run_sub[4];
  assign second_watchdog_run   = q.run_sub[5];
  assign main_domain_run       = q.run_main;

  // ==================================================
  // Checks
  stop_entry_a:
    assert property (@(posedge clk) disable iff (!resetn)
      $rose(q.st == SMS_STOP) |-> $past(q.pmode))
    else $error("stop entered without mode select");

  osc_halt_a:
    assert property (@(posedge clk) disable iff (!resetn)
      q.st == SMS_STOP |-> !main_osc_en)
    else $error("main oscillator running in stop");

  cpu_gate_a:
    assert property (@(posedge clk) disable iff (!resetn)
      q.st != SMS_NORMAL |-> !cpu_clk_en && !periph_main_clk_en)
    else $error("CPU clock running while stopped");

  mask_block_a:
    assert property (@(posedge clk) disable iff (!resetn)
      q.st == SMS_STOP && !wk_rst && !wk_mask && !wk_wd2
      && q.pctl[`SMS_PCTL_PNMK] |=> q.st == SMS_STOP)
    else $error("masked source ended stop");

  wake_go_a:
    assert property (@(posedge clk) disable iff (!resetn)
      q.st == SMS_STOP && (wk_nmi || wk_mask) |=> q.st == SMS_STAB)
    else $error("valid request did not end stop");

  stab_wait_a:
    assert property (@(posedge clk) disable iff (!resetn)
      $rose(q.st == SMS_STAB) && !q.rst_wake
      && q.cnt == 16'h0400 |-> !cpu_clk_en [*8])
    else $error("CPU restarted before wait");

  stab_len_a:
    assert property (@(posedge clk) disable iff (!resetn)
      $rose(q.st == SMS_STAB) && !q.rst_wake
      |-> q.cnt == stab_len($past(q.stab_sel)))
    else $error("wrong stabilization length");

  low_prio_a:
    assert property (@(posedge clk) disable iff (!resetn)
      wake_action == SMS_ACT_NEXT && $changed(wake_action)
      |-> !wake_ack && request_retained)
    else $error("low priority request was taken");

  ctrl_stop_a:
    assert property (@(posedge clk) disable iff (!resetn)
      q.st == SMS_STOP |-> !main_domain_run)
    else $error("main domain running in stop");

  port_keep_a:
    assert property (@(posedge clk) disable iff (!resetn)
      q.st == SMS_STOP |-> port_hold && ram_hold)
    else $error("ports not held in stop");

endmodule
`default_nettype wire
